// *** rtl/frd_pkg.sv ***
package frd_pkg;

  // Register byte addresses on the plain register port.
  localparam logic [3:0] FRD_ADDR_RESP = 4'h0;
  localparam logic [3:0] FRD_ADDR_UNIT = 4'h1;
  localparam logic [3:0] FRD_ADDR_STAT = 4'h2;
  localparam logic [3:0] FRD_ADDR_IRQ_STAT = 4'h3;
  localparam logic [3:0] FRD_ADDR_IRQ_EN = 4'h4;
  localparam logic [3:0] FRD_ADDR_IRQ_CLR = 4'h5;

  // Field positions of the fault-response byte.
  localparam int FRD_RESP_LSB = 6;
  localparam int FRD_RETRY_LSB = 3;
  localparam int FRD_DELAY_LSB = 0;

  // Reset values.
  localparam logic [7:0] FRD_RESP_RST = 8'h80;
  localparam logic [15:0] FRD_UNIT_RST = 16'h0001;

  // Retry code meaning unlimited restarts.
  localparam logic [2:0] FRD_RETRY_FOREVER = 3'h7;

  // Base tick: one microsecond at the 50 MHz clock.
  localparam int FRD_CLK_MHZ = 50;
  localparam int FRD_TICK_US = 1;
  localparam int FRD_TICK_CYC = FRD_CLK_MHZ * FRD_TICK_US;

  // Interrupt event bit positions.
  localparam int FRD_EV_FAULT = 0;
  localparam int FRD_EV_SHUT = 1;
  localparam int FRD_EV_RETRY = 2;
  localparam int FRD_EV_LATCH = 3;
  localparam int FRD_EV_N = 4;

  // Fault-response modes.
  typedef enum logic [1:0] {
    FRD_IGNORE = 2'h0,
    FRD_DELAY_RETRY = 2'h1,
    FRD_DISABLE_RETRY = 2'h2,
    FRD_DISABLE_RESUME = 2'h3
  } frd_mode_t;

  // Decoded fault-response byte.
  typedef struct packed {
    frd_mode_t mode;
    logic [2:0] retry;
    logic [2:0] delay;
  } frd_resp_t;

  // Sequencer view of the outside conditions.
  typedef struct packed {
    logic uv_fault;
    logic cmd_on;
    logic other_shutdown;
    logic start_ok;
  } frd_cond_t;

endpackage

// *** rtl/frd_ctrl.sv ***
`timescale 1ns/1ps
module frd_ctrl
  import frd_pkg::*;
(
  input wire logic clock,
  input wire logic rst_n,
  input wire logic [3:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr_en,
  input wire logic rd_en,
  output logic [7:0] rdata,
  input wire logic uv_fault,
  input wire logic cmd_on,
  input wire logic other_shutdown,
  input wire logic start_ok,
  input wire logic fault_clear,
  output logic out_enable,
  output logic irq
);

  // Sequencer states.  OFF follows reset, a command off or a fault clear and
  // is passed in one cycle once the command is on; the output stays low there
  // so that a new start always begins from a known point.
  // RUN is normal regulation and the only state that watches for a new
  // under-voltage fault; the response mode picks the next state.
  // RUNON keeps the output enabled while the shared delay runs; if the
  // fault goes away first the sequencer simply returns to RUN.
  // WAIT holds the output off for one full delay before an attempt, or
  // gives up at once when no attempts are allowed.
  // TRY enables the output for one cycle and starts the spacing to the
  // next attempt, so attempt starts are one delay plus two cycles apart.
  // HOLD keeps the output off while the fault lasts and leaves as soon
  // as it has gone, without using the delay or the attempt budget.
  // LATCH keeps the output off until the host clears the fault.
  // A command off wins over every other condition, and a shutdown forced
  // by another fault wins over the response to this one.
  // Limitation: an attempt counts as successful when the fault is absent
  // in the run cycle after TRY; the start indication is not used, so a
  // slow soft start must keep the fault input low while it ramps.
  // The state code is readable in the status register, so the order of
  // the names below is part of the software view and must not change.
  // Timing summary with the default one-microsecond unit: a delay code
  // of n lasts two to the power n units, each unit being fifty clock
  // cycles, and the prescaler restart at each load makes that exact.
  // An attempt interval is therefore one delay plus two cycles: the attempt
  // cycle, which makes the load, and the wait cycle that sees the count end.
  // The unit register is kept apart from the response byte because one
  // unit setting belongs to this fault alone; other fault types would
  // carry their own unit registers in the same way.
  // The run-on and the retry spacing share one delay path, which keeps the block
  // small at the cost of not being able to time both at once.
  // Nothing here needs both at once: a run-on ends before waiting starts.
  // Command off is taken as a level, not an edge, so holding it low
  // keeps the sequencer parked in OFF however long the fault lasts.
  typedef enum logic [2:0] {
    FRD_S_OFF,
    FRD_S_RUN,
    FRD_S_RUNON,
    FRD_S_WAIT,
    FRD_S_TRY,
    FRD_S_HOLD,
    FRD_S_LATCH
  } frd_state_t;

  frd_resp_t resp_q;
  logic [15:0] unit_q;
  logic [FRD_EV_N-1:0] irq_stat_q;
  logic [FRD_EV_N-1:0] irq_en_q;
  logic [FRD_EV_N-1:0] ev;
  frd_state_t state_q;
  frd_cond_t cond;
  logic [5:0] tick_cnt_q;
  logic tick;
  logic [15:0] unit_cnt_q;
  logic unit_tick;
  logic [7:0] delay_cnt_q;
  logic delay_done;
  logic delay_load;
  logic [2:0] tries_q;
  logic cmd_on_q;
  logic on_rise;
  logic budget_left;
  logic retry_run_q;
  logic [FRD_EV_N-1:0] irq_clr;

  assign cond = '{uv_fault: uv_fault, cmd_on: cmd_on,
                  other_shutdown: other_shutdown, start_ok: start_ok};
  assign on_rise = cond.cmd_on && !cmd_on_q;

  // Configuration registers written by the host.
  // Writes to read-only or unmapped addresses are dropped silently.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      resp_q <= frd_resp_t'(FRD_RESP_RST);
      unit_q <= FRD_UNIT_RST;
      irq_en_q <= '0;
    end else if (wr_en) begin
      case (addr)
        FRD_ADDR_RESP: resp_q <= frd_resp_t'(wdata);
        // The unit count is programmed in its own register.
        FRD_ADDR_UNIT: unit_q <= {8'h00, wdata};
        FRD_ADDR_IRQ_EN: irq_en_q <= wdata[FRD_EV_N-1:0];
        default: ;
      endcase
    end
  end

  // Write-one-to-clear strobes, one bit per event.
  assign irq_clr = (wr_en && addr == FRD_ADDR_IRQ_CLR) ?
                   wdata[FRD_EV_N-1:0] : '0;

  // Sticky interrupt status, one flop per event.  A new event wins over
  // a clear in the same cycle, so an event that arrives in the cycle of the
  // clear is kept; one that arrives between the read and the clear is cleared too.
  for (genvar i = 0; i < FRD_EV_N; i++) begin : g_stat
    always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
        irq_stat_q[i] <= 1'b0;
      end else if (ev[i]) begin
        irq_stat_q[i] <= 1'b1;
      end else if (irq_clr[i]) begin
        irq_stat_q[i] <= 1'b0;
      end
    end
  end

  assign irq = |(irq_stat_q & irq_en_q);

  // Read data appear the cycle after the strobe; unmapped reads give zero.
  // The port never stalls, so every read is answered in exactly one cycle.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rdata <= 8'h00;
    end else if (rd_en) begin
      case (addr)
        FRD_ADDR_RESP: rdata <= resp_q;
        FRD_ADDR_UNIT: rdata <= unit_q[7:0];
        FRD_ADDR_STAT: rdata <= {2'h0, tries_q, state_q};
        FRD_ADDR_IRQ_STAT: rdata <= {4'h0, irq_stat_q};
        FRD_ADDR_IRQ_EN: rdata <= {4'h0, irq_en_q};
        default: rdata <= 8'h00;
      endcase
    end else begin
      rdata <= 8'h00;
    end
  end

  // Microsecond prescaler so that the unit counter stays narrow.  It is
  // restarted with every delay load: left free-running, its phase would
  // cut the first unit of a delay short by up to a whole microsecond.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      tick_cnt_q <= '0;
    end else if (delay_load) begin
      tick_cnt_q <= '0;
    end else if (tick) begin
      tick_cnt_q <= '0;
    end else begin
      tick_cnt_q <= tick_cnt_q + 6'h01;
    end
  end

  assign tick = tick_cnt_q == 6'(FRD_TICK_CYC - 1);

  // Time-unit divider for this fault; a zero unit acts as one tick.
  // Only the low byte is programmable, which caps one unit at 255 us;
  // the upper byte stays zero so that the counter width need not change.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      unit_cnt_q <= '0;
    end else if (delay_load) begin
      unit_cnt_q <= '0;
    end else if (tick) begin
      unit_cnt_q <= unit_tick ? 16'h0000 : unit_cnt_q + 16'h0001;
    end
  end

  assign unit_tick = tick && (unit_cnt_q + 16'h0001 >= unit_q);

  // Delay counter loaded with two to the power of the delay code.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      delay_cnt_q <= '0;
    end else if (delay_load) begin
      delay_cnt_q <= 8'h01 << resp_q.delay;
    end else if (unit_tick && delay_cnt_q != 8'h00) begin
      delay_cnt_q <= delay_cnt_q - 8'h01;
    end
  end

  assign delay_done = delay_cnt_q == 8'h00;

  // Edge detector for a fresh enable command.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      cmd_on_q <= 1'b0;
    end else begin
      cmd_on_q <= cond.cmd_on;
    end
  end

  // Marks the first run cycle after a restart attempt, where a fault that
  // is still present means the attempt failed.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      retry_run_q <= 1'b0;
    end else begin
      retry_run_q <= state_q == FRD_S_TRY;
    end
  end

  // Attempts still allowed; code 111 never runs out.  The counter
  // saturates at 7 under that code, so it never wraps back to zero.
  assign budget_left = (resp_q.retry == FRD_RETRY_FOREVER) ||
                       (tries_q < resp_q.retry);

  // Load the shared delay on each entry to a timed state.
  // The run cycle right after an attempt does not reload: the spacing
  // to the next attempt already started in the attempt cycle itself.
  // A run-on that expires loads the same delay once more, so the first
  // attempt after it is also one full delay away.
  always_comb begin
    delay_load = 1'b0;
    case (state_q)
      FRD_S_RUN: delay_load = cond.uv_fault && !retry_run_q;
      FRD_S_RUNON: delay_load = cond.uv_fault && delay_done;
      FRD_S_TRY: delay_load = 1'b1;
      default: delay_load = 1'b0;
    endcase
  end

  // Restart attempt counter, cleared by fault clear or new enable.
  // The clear takes priority over a count in the same cycle, so a host
  // clear always leaves the full budget for the next fault.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      tries_q <= '0;
    end else if (fault_clear || on_rise) begin
      tries_q <= '0;
    end else if (state_q == FRD_S_WAIT && delay_done && budget_left &&
                 tries_q != FRD_RETRY_FOREVER) begin
      tries_q <= tries_q + 3'h1;
    end
  end

  // Fault-response sequencer.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= FRD_S_OFF;
    end else if (!cond.cmd_on) begin
      state_q <= FRD_S_OFF;
    end else if (cond.other_shutdown) begin
      state_q <= FRD_S_LATCH;
    end else begin
      case (state_q)
        FRD_S_OFF: state_q <= FRD_S_RUN;
        FRD_S_RUN: begin
          if (cond.uv_fault && retry_run_q) begin
            // A failed attempt goes straight back to waiting.
            state_q <= FRD_S_WAIT;
          end else if (cond.uv_fault) begin
            case (resp_q.mode)
              FRD_IGNORE: state_q <= FRD_S_RUN;
              FRD_DELAY_RETRY: state_q <= FRD_S_RUNON;
              FRD_DISABLE_RETRY: state_q <= FRD_S_WAIT;
              default: state_q <= FRD_S_HOLD;
            endcase
          end
        end
        FRD_S_RUNON: begin
          if (!cond.uv_fault) begin
            state_q <= FRD_S_RUN;
          end else if (delay_done) begin
            state_q <= FRD_S_WAIT;
          end
        end
        FRD_S_WAIT: begin
          // Spacing between attempts is one full delay plus two cycles.
          // Code 000 gives up without waiting for the delay.
          if (resp_q.retry == 3'h0) begin
            state_q <= FRD_S_LATCH;
          end else if (delay_done) begin
            state_q <= budget_left ? FRD_S_TRY : FRD_S_LATCH;
          end
        end
        FRD_S_TRY: state_q <= FRD_S_RUN;
        FRD_S_HOLD: begin
          if (!cond.uv_fault) begin
            state_q <= FRD_S_RUN;
          end
        end
        FRD_S_LATCH: begin
          if (fault_clear) begin
            state_q <= FRD_S_OFF;
          end
        end
        default: state_q <= FRD_S_OFF;
      endcase
    end
  end

  // A restart attempt re-enables the output; if the fault persists the
  // run state sees it again and the next wait begins.
  always_comb begin
    case (state_q)
      FRD_S_RUN: out_enable = 1'b1;
      FRD_S_RUNON: out_enable = 1'b1;
      FRD_S_TRY: out_enable = 1'b1;
      default: out_enable = 1'b0;
    endcase
  end

  // Events for the interrupt status register.
  // Each event is taken from the state and the inputs; all but the fault event in ignore mode last one cycle;
  // the sticky status bits above turn it into something software can see.
  always_comb begin
    ev = '0;
    ev[FRD_EV_FAULT] = state_q == FRD_S_RUN && cond.uv_fault;
    ev[FRD_EV_SHUT] = state_q == FRD_S_RUNON && cond.uv_fault && delay_done;
    ev[FRD_EV_RETRY] = state_q == FRD_S_TRY;
    ev[FRD_EV_LATCH] = state_q == FRD_S_WAIT && state_q != FRD_S_LATCH &&
                       (resp_q.retry == 3'h0 || (delay_done && !budget_left));
  end

endmodule

// *** tb/frd_host.sv ***
`timescale 1ns/1ps
// Host on the register port; released lines show the inverse value.
module frd_host
  import frd_pkg::*;
(
  input wire logic clock,
  output logic [3:0] addr,
  output logic [7:0] wdata,
  output logic wr_en,
  output logic rd_en,
  input wire logic [7:0] rdata
);
  initial begin
    addr = 4'h0;
    wdata = 8'h00;
    wr_en = 1'b0;
    rd_en = 1'b0;
  end
  // The trailing delay keeps two strobe updates out of one time step.
  task automatic wr(input logic [3:0] a, input logic [7:0] v);
    addr <= a;
    wdata <= v;
    wr_en <= 1'b1;
    @(posedge clock);
    wr_en <= 1'b0;
    addr <= ~a;
    wdata <= ~v;
    #1;
  endtask
  // Read data stand only in the cycle after the strobe.
  task automatic rd(input logic [3:0] a, output logic [7:0] v);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge clock);
    rd_en <= 1'b0;
    addr <= ~a;
    #1 v = rdata;
  endtask
endmodule

// *** tb/frd_ctrl_assertions.sv ***
`timescale 1ns/1ps
module frd_ctrl_assertions
  import frd_pkg::*;
(
  input wire logic clock,
  input wire logic rst_n,
  input wire logic [3:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr_en,
  input wire logic rd_en,
  input wire logic [7:0] rdata,
  input wire logic uv_fault,
  input wire logic cmd_on,
  input wire logic other_shutdown,
  input wire logic start_ok,
  input wire logic fault_clear,
  input wire logic out_enable,
  input wire logic irq
);
  logic [7:0] resp_q;
  // Shadow of the response byte, since the mode decides what is legal.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      resp_q <= FRD_RESP_RST;
    end else if (wr_en && addr == FRD_ADDR_RESP) begin
      resp_q <= wdata;
    end
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);
  rd_idle_a: assert property (!$past(rd_en) |-> rdata == 8'h00)
    else $error("read data not zero outside a read");
  rd_resp_a: assert property ($past(rd_en) &&
    $past(addr) == FRD_ADDR_RESP |-> rdata == resp_q)
    else $error("response byte read back wrong");
  rd_unmap_a: assert property ($past(rd_en) &&
    $past(addr) > FRD_ADDR_IRQ_CLR |-> rdata == 8'h00)
    else $error("unmapped read not zero");
  cmd_off_a: assert property (!cmd_on |=> !out_enable)
    else $error("output on after command off");
  other_off_a: assert property (other_shutdown |=> !out_enable)
    else $error("output on after other shutdown");
  ignore_run_a: assert property (resp_q[7:6] == 2'h0 &&
    out_enable && cmd_on && !other_shutdown |=> out_enable)
    else $error("output dropped in ignore mode");
  disable_now_a: assert property (resp_q[7:6] == 2'h2 &&
    uv_fault && out_enable && $past(out_enable) |=> !out_enable)
    else $error("output not disabled at once");
  hold_off_a: assert property (resp_q[7:6] == 2'h3 &&
    uv_fault |=> !out_enable)
    else $error("output on while fault held");
  cover property (resp_q[7:6] == 2'h1 && $fell(out_enable));
  cover property ($rose(irq));
  cover property (resp_q[5:3] == FRD_RETRY_FOREVER && $rose(out_enable));
endmodule

// *** tb/fault_retry_delay_control_test.sv ***
`timescale 1ns/1ps
module fault_retry_delay_control_test import frd_pkg::*;;
  logic clock, rst_n, uv_fault, cmd_on, other_shutdown, fault_clear;
  logic wr_en, rd_en, out_enable, irq;
  logic [3:0] addr;
  logic [7:0] wdata, rdata, d;
  int error_cnt = 0;
  int n_checks = 0;
  int cyc_n = 0;
  int n, g;
  frd_host h (.clock(clock), .addr(addr), .wdata(wdata), .wr_en(wr_en),
    .rd_en(rd_en), .rdata(rdata));
  frd_ctrl dut (.clock(clock), .rst_n(rst_n), .addr(addr), .wdata(wdata),
    .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata), .uv_fault(uv_fault),
    .cmd_on(cmd_on), .other_shutdown(other_shutdown), .start_ok(1'b0),
    .fault_clear(fault_clear), .out_enable(out_enable), .irq(irq));
  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end
  task chk(input logic [15:0] s, input logic [15:0] e);
    n_checks++;
    if (s !== e) begin
      error_cnt++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task give_verdict;
    $display("checks %0d mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // Ends just after an edge so outputs have settled.
  task cy(input int k);
    repeat (k) @(posedge clock);
    #1;
  endtask
  // Counts output rises in a window; g is the gap before the last one.
  task rises(input int k, output int c, output int g);
    int t;
    logic p;
    c = 0;
    t = 0;
    p = out_enable;
    repeat (k) begin
      cy(1);
      t++;
      if (out_enable && !p) begin
        c++;
        g = t;
        t = 0;
      end
      p = out_enable;
    end
  endtask
  task clr;
    uv_fault <= 1'b0;
    fault_clear <= 1'b1;
    cy(1);
    fault_clear <= 1'b0;
    cy(4);
  endtask
  task t_reg;
    h.rd(FRD_ADDR_RESP, d);
    chk(d, FRD_RESP_RST);
    h.rd(4'hF, d);
    chk(d, 8'h00);
    $display("t_reg done");
  endtask
  // Masking the interrupt while the output holds off, clearing it after the output returns, then ignore mode.
  task t_hold;
    h.wr(FRD_ADDR_IRQ_EN, 8'h01);
    h.wr(FRD_ADDR_RESP, 8'hC0);
    uv_fault <= 1'b1;
    cy(3);
    chk(out_enable, 1'b0);
    chk(irq, 1'b1);
    h.wr(FRD_ADDR_IRQ_EN, 8'h00);
    cy(2);
    chk(irq, 1'b0);
    h.wr(FRD_ADDR_IRQ_EN, 8'h01);
    uv_fault <= 1'b0;
    cy(3);
    chk(out_enable, 1'b1);
    chk(irq, 1'b1);
    h.wr(FRD_ADDR_IRQ_CLR, 8'h0F);
    cy(2);
    chk(irq, 1'b0);
    h.wr(FRD_ADDR_RESP, 8'h00);
    uv_fault <= 1'b1;
    cy(200);
    chk(out_enable, 1'b1);
    uv_fault <= 1'b0;
    $display("t_hold done");
  endtask
  // Run-on length scales with the unit setting; no retry then latches.
  task t_runon;
    for (int u = 1; u < 3; u++) begin
      h.wr(FRD_ADDR_UNIT, 8'(u));
      h.wr(FRD_ADDR_RESP, 8'h41);
      uv_fault <= 1'b1;
      n = 0;
      while (out_enable === 1'b1 && n < 500) begin
        cy(1);
        n++;
      end
      chk(n >= 100 * u && n <= 100 * u + 3, 1'b1);
      cy(10);
      h.rd(FRD_ADDR_STAT, d);
      chk(d[2:0], 3'h6);
      clr;
    end
    h.wr(FRD_ADDR_UNIT, 8'h01);
    $display("t_runon done");
  endtask
  // Retry codes 0 to 6 each give their count of attempts, spaced 50 to 52 cycles apart.
  task t_retry;
    for (int r = 0; r < 7; r++) begin
      h.wr(FRD_ADDR_RESP, {2'h2, 3'(r), 3'h0});
      uv_fault <= 1'b1;
      rises(60 * r + 100, n, g);
      chk(16'(n), 16'(r));
      if (r > 1) chk(g >= 50 && g <= 52, 1'b1);
      chk(out_enable, 1'b0);
      clr;
    end
    $display("t_retry done");
  endtask
  task t_forever;
    h.wr(FRD_ADDR_RESP, 8'hB8);
    uv_fault <= 1'b1;
    rises(700, n, g);
    chk(n > 10, 1'b1);
    cmd_on <= 1'b0;
    rises(200, n, g);
    chk(16'(n), 16'h0000);
    cmd_on <= 1'b1;
    cy(3);
    other_shutdown <= 1'b1;
    cy(1);
    other_shutdown <= 1'b0;
    rises(200, n, g);
    chk(16'(n), 16'h0000);
    clr;
    $display("t_forever done");
  endtask
  // A hung wait is cut off well above the expected run length.
  always @(posedge clock) begin
    cyc_n++;
    if (cyc_n == 20000) begin
      error_cnt++;
      give_verdict;
    end
  end
  initial begin
    rst_n = 1'b0;
    uv_fault = 1'b0;
    cmd_on = 1'b1;
    other_shutdown = 1'b0;
    fault_clear = 1'b0;
    repeat (16) @(posedge clock);
    rst_n <= 1'b1;
    cy(3);
    chk(out_enable, 1'b1);
    t_reg;
    t_hold;
    t_runon;
    t_retry;
    t_forever;
    give_verdict;
  end
endmodule
bind frd_ctrl frd_ctrl_assertions u_chk (.clock(clock), .rst_n(rst_n),
  .addr(addr), .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata),
  .uv_fault(uv_fault), .cmd_on(cmd_on), .other_shutdown(other_shutdown),
  .start_ok(start_ok), .fault_clear(fault_clear), .out_enable(out_enable),
  .irq(irq));
